//--- src/lut_pkg.sv
package lut_pkg;
    // register indices (byte address = index * 4)
    localparam logic [15:0] LUT_IDX_CMD = 16'h1800;
    localparam logic [15:0] LUT_IDX_WR_LO = 16'h1801;
    localparam logic [15:0] LUT_IDX_WR_HI = 16'h1802;
    localparam logic [15:0] LUT_IDX_RD_LO = 16'h1805;
    localparam logic [15:0] LUT_IDX_RD_HI = 16'h1806;
    localparam logic [15:0] LUT_IDX_STS = 16'h1808;
    // command bits
    localparam int LUT_CMD_MAKE = 2;
    localparam int LUT_CMD_FIRST = 1;
    localparam int LUT_CMD_NEXT = 0;
    // upper word fields
    localparam int LUT_VALID_BIT = 24;
    localparam int LUT_END_BIT = 23;
    localparam int LUT_STATIC_BIT = 22;
    localparam int LUT_MULTI_BIT = 18;
    localparam int LUT_PORT_LSB = 16;
    localparam int LUT_MAC_HI_W = 16;
    localparam logic [24:0] LUT_HI_MASK = 25'h1ffffff;
    localparam logic [31:0] LUT_RD_LO_RST = 32'h00000000;
    localparam logic [31:0] LUT_WR_HI_RST = 32'h00000000;
    localparam logic [31:0] LUT_STS_BUSY = 32'h00000001;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lut_bus_s;

    typedef struct packed {
        logic valid;
        logic [24:0] hi;
        logic [31:0] lo;
    } lut_entry_s;
endpackage

//--- src/lut_regs.sv
`timescale 1ns/1ps
// Operation
// RULE1: port field bit 18 selects single port (0) or port set (1)
// RULE2: single codes 000 host, 001 port one, 010 port two; 011 reserved
// RULE3: set codes 100 h+1, 101 h+2, 110 1+2, 111 all three
// RULE4: write-high bits 15:0 hold last 16 MAC bits of new entry
// RULE5: write-high bit 15 is MSB of last MAC byte, last on wire
// RULE6: write-high port and MAC fields read/write, reset zero, feed make
// RULE7: read-low loaded with first 32 entry bits by first/next fetch
// RULE8: software trusts read-low only when valid or table-end flag set; code sets table-end on a miss at the top slot without loading read-low
// RULE9: read-low bit 0 is LSB of first MAC byte, multicast bit
// RULE10: read-low is read-only and resets to zero
// RULE11: first fetch resets pointer, finds first valid entry, loads both words
// RULE12: next fetch advances to next valid entry, loads both words
// RULE13: valid flag clears on fetch, sets on hit, stays clear at top
// RULE14: table-end flag sets when search reaches the top slot (DEPTH - 1)
// RULE15: read words hold stable until next fetch completes
module lut_regs
    import lut_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire lut_bus_s bus,
    output logic [31:0] rdata,
    output logic [2:0] port_mask,
    output logic busy
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH > 65536) begin : g_depth_chk
        $error("DEPTH out of range");
    end

    typedef enum {ST_IDLE, ST_SCAN, ST_LOAD} lut_state_e;

    lut_entry_s table_mem [DEPTH];
    logic [31:0] wr_lo_ff, nxt_wr_lo;
    logic [24:0] wr_hi_ff, nxt_wr_hi;
    logic [31:0] rd_lo_ff, nxt_rd_lo;
    logic [24:0] rd_hi_ff, nxt_rd_hi;
    logic [2:0] cmd_ff, nxt_cmd;
    logic [AW-1:0] ptr_ff, nxt_ptr;
    logic [AW-1:0] wptr_ff, nxt_wptr;
    lut_state_e st_ff, nxt_st;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [2:0] pmask_ff, nxt_pmask;
    logic busy_ff, nxt_busy;
    logic mk_ff, nxt_mk;
    lut_entry_s cur;
    // per-slot valid flags, cleared by reset so a scan never meets unknowns
    logic [DEPTH-1:0] vld_ff, nxt_vld;
    logic cur_hit;

    function automatic logic [2:0] port_decode(input logic [2:0] code);
        if (!code[2]) begin // [RULE1]
            case (code[1:0]) // [RULE2]
                2'h0: return 3'h1;
                2'h1: return 3'h2;
                2'h2: return 3'h4;
                default: return 3'h0;
            endcase
        end
        case (code[1:0]) // [RULE3]
            2'h0: return 3'h3;
            2'h1: return 3'h5;
            2'h2: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction

    assign cur = table_mem[ptr_ff];
    assign cur_hit = vld_ff[ptr_ff];
    assign rdata = rdata_ff;
    assign port_mask = pmask_ff;
    assign busy = busy_ff;

    always_comb begin
        nxt_wr_lo = wr_lo_ff;
        nxt_wr_hi = wr_hi_ff;
        nxt_rd_lo = rd_lo_ff;
        nxt_rd_hi = rd_hi_ff;
        nxt_cmd = cmd_ff;
        nxt_ptr = ptr_ff;
        nxt_wptr = wptr_ff;
        nxt_vld = vld_ff;
        nxt_st = st_ff;
        nxt_mk = 1'b0;
        nxt_rdata = 32'h00000000;
        nxt_pmask = port_decode(wr_hi_ff[LUT_MULTI_BIT:LUT_PORT_LSB]);
        if (bus.wr) begin
            if (bus.addr == LUT_IDX_WR_LO) begin
                nxt_wr_lo = bus.wdata;
            end else if (bus.addr == LUT_IDX_WR_HI) begin
                nxt_wr_hi = bus.wdata[24:0] & LUT_HI_MASK; // [RULE4] [RULE5] [RULE6]
            end else if (bus.addr == LUT_IDX_CMD) begin
                nxt_cmd = bus.wdata[2:0];
                if (st_ff == ST_IDLE && bus.wdata[LUT_CMD_MAKE]
                        && !cmd_ff[LUT_CMD_MAKE]) begin
                    nxt_mk = 1'b1; // [RULE6]
                end
                if (st_ff == ST_IDLE && bus.wdata[LUT_CMD_FIRST]
                        && !cmd_ff[LUT_CMD_FIRST]) begin
                    nxt_ptr = '0; // [RULE11]
                    nxt_rd_hi[LUT_VALID_BIT] = 1'b0; // [RULE13]
                    nxt_rd_hi[LUT_END_BIT] = 1'b0;
                    nxt_st = ST_SCAN;
                end else if (st_ff == ST_IDLE && bus.wdata[LUT_CMD_NEXT]
                        && !cmd_ff[LUT_CMD_NEXT]) begin
                    nxt_rd_hi[LUT_VALID_BIT] = 1'b0; // [RULE13]
                    if (rd_hi_ff[LUT_END_BIT]) begin
                        nxt_st = ST_IDLE; // [RULE14]
                    end else begin
                        nxt_st = ST_SCAN; // [RULE12]
                    end
                end
            end
        end
        case (st_ff)
            ST_SCAN: begin
                if (cur_hit) begin
                    nxt_st = ST_LOAD;
                end else if (ptr_ff == AW'(DEPTH - 1)) begin
                    nxt_rd_hi[LUT_END_BIT] = 1'b1; // [RULE13] [RULE14]
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_ptr = ptr_ff + 1'b1;
                end
            end
            ST_LOAD: begin
                nxt_rd_lo = cur.lo; // [RULE7] [RULE9] [RULE15]
                nxt_rd_hi = cur.hi;
                nxt_rd_hi[LUT_VALID_BIT] = 1'b1; // [RULE13]
                nxt_rd_hi[LUT_END_BIT] = (ptr_ff == AW'(DEPTH - 1)); // [RULE14]
                if (ptr_ff != AW'(DEPTH - 1)) begin
                    nxt_ptr = ptr_ff + 1'b1; // [RULE12]
                end
                nxt_st = ST_IDLE;
            end
            default: begin
            end
        endcase
        nxt_busy = (nxt_st != ST_IDLE);
        if (bus.rd) begin
            if (bus.addr == LUT_IDX_RD_LO) begin
                nxt_rdata = rd_lo_ff; // [RULE8] [RULE10]
            end else if (bus.addr == LUT_IDX_RD_HI) begin
                nxt_rdata = {7'h00, rd_hi_ff};
            end else if (bus.addr == LUT_IDX_WR_LO) begin
                nxt_rdata = wr_lo_ff;
            end else if (bus.addr == LUT_IDX_WR_HI) begin
                nxt_rdata = {7'h00, wr_hi_ff}; // [RULE6]
            end else if (bus.addr == LUT_IDX_CMD) begin
                nxt_rdata = {29'h00000000, cmd_ff};
            end else if (bus.addr == LUT_IDX_STS) begin
                nxt_rdata = busy_ff ? LUT_STS_BUSY : 32'h00000000;
            end else begin
                nxt_rdata = 32'h00000000;
            end
        end
        // make stores into the next slot, round robin
        if (mk_ff) begin
            nxt_vld[wptr_ff] = wr_hi_ff[LUT_VALID_BIT]; // [RULE6]
            if (wptr_ff == AW'(DEPTH - 1)) begin
                nxt_wptr = '0;
            end else begin
                nxt_wptr = wptr_ff + 1'b1;
            end
        end
    end

    // manual entry store; slot chosen round robin
    always_ff @(posedge sys_clk) begin
        if (mk_ff) begin
            table_mem[wptr_ff] <= '{valid: wr_hi_ff[LUT_VALID_BIT],
                hi: wr_hi_ff & ~(25'h1 << LUT_VALID_BIT), lo: wr_lo_ff};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_lo_ff <= 32'h00000000;
            wr_hi_ff <= LUT_WR_HI_RST[24:0]; // [RULE6]
            rd_lo_ff <= LUT_RD_LO_RST; // [RULE10]
            rd_hi_ff <= '0;
            cmd_ff <= 3'h0;
            ptr_ff <= '0;
            wptr_ff <= '0;
            vld_ff <= '0;
            st_ff <= ST_IDLE;
            rdata_ff <= 32'h00000000;
            pmask_ff <= 3'h0;
            busy_ff <= 1'b0;
            mk_ff <= 1'b0;
        end else begin
            wr_lo_ff <= nxt_wr_lo;
            wr_hi_ff <= nxt_wr_hi;
            rd_lo_ff <= nxt_rd_lo;
            rd_hi_ff <= nxt_rd_hi;
            cmd_ff <= nxt_cmd;
            ptr_ff <= nxt_ptr;
            vld_ff <= nxt_vld;
            wptr_ff <= nxt_wptr;
            st_ff <= nxt_st;
            rdata_ff <= nxt_rdata;
            pmask_ff <= nxt_pmask;
            busy_ff <= nxt_busy;
            mk_ff <= nxt_mk;
        end
    end

    a_rd_lo_hold: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff != ST_LOAD |=> $stable(rd_lo_ff)) // [RULE15]
        else $error("read low changed outside load");
    a_rd_lo_ro: assert property (@(posedge sys_clk) disable iff (rst)
        bus.wr && bus.addr == LUT_IDX_RD_LO && st_ff == ST_IDLE
        |=> rd_lo_ff == $past(rd_lo_ff)) // [RULE10]
        else $error("read low written by software");
    a_load_data: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_LOAD |=> rd_lo_ff == $past(cur.lo)) // [RULE7]
        else $error("read low not loaded");
    a_valid_clear: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_IDLE && bus.wr && bus.addr == LUT_IDX_CMD
        && bus.wdata[LUT_CMD_FIRST] && !cmd_ff[LUT_CMD_FIRST]
        |=> !rd_hi_ff[LUT_VALID_BIT] && st_ff == ST_SCAN) // [RULE13]
        else $error("valid not cleared on fetch");
    a_valid_set: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_LOAD |=> rd_hi_ff[LUT_VALID_BIT]) // [RULE13]
        else $error("valid not set on hit");
    a_end_flag: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_SCAN && !cur_hit && ptr_ff == AW'(DEPTH - 1)
        |=> rd_hi_ff[LUT_END_BIT] && !rd_hi_ff[LUT_VALID_BIT]) // [RULE14]
        else $error("end flag missing");
    a_first_ptr: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_IDLE && nxt_st == ST_SCAN && bus.wdata[LUT_CMD_FIRST]
        |=> ptr_ff == '0) // [RULE11]
        else $error("pointer not reset");
    a_wr_hi_store: assert property (@(posedge sys_clk) disable iff (rst)
        bus.wr && bus.addr == LUT_IDX_WR_HI
        |=> wr_hi_ff[15:0] == $past(bus.wdata[15:0])) // [RULE4]
        else $error("write high mac bits lost");
    a_port_map: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 wr_hi_ff[18:16] == 3'h7 |=> pmask_ff == 3'h7) // [RULE3]
        else $error("port map wrong");
    c_first_hit: cover property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_LOAD ##1 rd_hi_ff[LUT_VALID_BIT]);
    c_end_miss: cover property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_SCAN ##1 rd_hi_ff[LUT_END_BIT]);
    c_make: cover property (@(posedge sys_clk) disable iff (rst) mk_ff);
    c_next_hit: cover property (@(posedge sys_clk) disable iff (rst)
        st_ff == ST_LOAD && ptr_ff != '0);
    c_rd_low: cover property (@(posedge sys_clk) disable iff (rst)
        bus.rd && bus.addr == LUT_IDX_RD_LO ##1 rdata_ff != 32'h0);

    // port field decode
    a_port_single: assert property ( // [RULE1] [RULE2]
        @(posedge sys_clk) disable iff (rst)
        !wr_hi_ff[LUT_MULTI_BIT] && wr_hi_ff[LUT_PORT_LSB +: 2] != 2'h3
        |=> $onehot(pmask_ff))
        else $error("single port code not one port");
    a_port_multi: assert property ( // [RULE3]
        @(posedge sys_clk) disable iff (rst)
        wr_hi_ff[LUT_MULTI_BIT]
        |=> $countones(pmask_ff) >= 2)
        else $error("port set code not several ports");
    a_port_resv: assert property ( // [RULE2]
        @(posedge sys_clk) disable iff (rst)
        wr_hi_ff[LUT_MULTI_BIT:LUT_PORT_LSB] == 3'h3
        |=> pmask_ff == 3'h0)
        else $error("reserved code selects a port");

    // read words and fetch sequencing
    a_rd_hi_hold: assert property ( // [RULE15]
        @(posedge sys_clk) disable iff (rst)
        st_ff == ST_IDLE && !(bus.wr && bus.addr == LUT_IDX_CMD)
        |=> $stable(rd_hi_ff))
        else $error("read high changed while idle");
    a_next_clear: assert property ( // [RULE13]
        @(posedge sys_clk) disable iff (rst)
        st_ff == ST_IDLE && bus.wr && bus.addr == LUT_IDX_CMD
        && bus.wdata[LUT_CMD_NEXT] && !cmd_ff[LUT_CMD_NEXT]
        |=> !rd_hi_ff[LUT_VALID_BIT])
        else $error("valid not cleared on next");
    a_scan_step: assert property ( // [RULE12]
        @(posedge sys_clk) disable iff (rst)
        st_ff == ST_SCAN && !cur_hit && ptr_ff != AW'(DEPTH - 1)
        |=> ptr_ff == $past(ptr_ff) + 1'b1)
        else $error("scan did not advance");
    a_fetch_busy: assert property ( // [RULE11]
        @(posedge sys_clk) disable iff (rst)
        st_ff == ST_IDLE && bus.wr && bus.addr == LUT_IDX_CMD
        && bus.wdata[LUT_CMD_FIRST] && !cmd_ff[LUT_CMD_FIRST]
        |=> busy_ff)
        else $error("busy not raised on fetch");
    a_load_hi: assert property ( // [RULE12]
        @(posedge sys_clk) disable iff (rst)
        st_ff == ST_LOAD
        |=> rd_hi_ff[15:0] == $past(cur.hi[15:0]))
        else $error("read high mac bits not loaded");

    // register port and entry make
    a_rdata_quiet: assert property (
        @(posedge sys_clk) disable iff (rst)
        !bus.rd |=> rdata_ff == 32'h00000000)
        else $error("read data without strobe");
    a_rd_lo_read: assert property ( // [RULE10]
        @(posedge sys_clk) disable iff (rst)
        bus.rd && bus.addr == LUT_IDX_RD_LO
        |=> rdata_ff == $past(rd_lo_ff))
        else $error("read low returned wrong word");
    a_wr_lo_store: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (rst)
        bus.wr && bus.addr == LUT_IDX_WR_LO
        |=> wr_lo_ff == $past(bus.wdata))
        else $error("write low not stored");
    a_mk_valid: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (rst)
        mk_ff
        |=> vld_ff[$past(wptr_ff)] == $past(wr_hi_ff[LUT_VALID_BIT]))
        else $error("made entry valid flag wrong");
endmodule

//--- verif/lut_regs_bench.sv
`timescale 1ns/1ps
module lut_regs_bench;
    import lut_pkg::*;
    localparam logic [31:0] HI_MSK = 32'h01ffffff;
    logic sys_clk;
    logic rst;
    lut_bus_s bus;
    logic [31:0] rdata;
    logic [2:0] port_mask;
    logic busy;
    int fail_count;
    int compares;
    logic [31:0] hi_word;
    logic [2:0] masks [8] = '{3'b001, 3'b010, 3'b100, 3'b000,
                              3'b011, 3'b101, 3'b110, 3'b111};

    lut_regs #(
        .DEPTH(4)
    ) u_lut_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(bus),
        .rdata(rdata),
        .port_mask(port_mask),
        .busy(busy)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    // read, mask and compare the word that stands after the strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        check(rdata & m, exp);
    endtask

    // pulse a command bit, clear it, wait for the search to finish
    task automatic cmd(input int bitpos);
        int n;
        wr(LUT_IDX_CMD, 32'h1 << bitpos);
        wr(LUT_IDX_CMD, 32'h0);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, busy}, 32'h0);
    endtask

    task automatic results;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        results();
    end

    initial begin
        bus = '0;
        rst = 1'b1;
        fail_count = 0;
        compares = 0;
        hi_word = 32'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(LUT_IDX_RD_LO, 32'hffffffff, LUT_RD_LO_RST);
        rd(LUT_IDX_WR_HI, 32'hffffffff, LUT_WR_HI_RST);
        rd(16'h1803, 32'hffffffff, 32'h0);
        // every legal port code, with last-byte MSB set and the code in bits 6:4
        for (int c = 0; c < 8; c++) begin
            if (c != 3) begin
                hi_word = {13'h0, 3'(c), 16'h8000 | 16'(c << 4)};
                wr(LUT_IDX_WR_HI, hi_word);
                rd(LUT_IDX_WR_HI, HI_MSK, hi_word);
                check({29'h0, port_mask}, {29'h0, masks[c]});
            end
        end
        // two manual entries into a four-slot table
        wr(LUT_IDX_WR_LO, 32'hc0a81101);
        wr(LUT_IDX_WR_HI, 32'h0141a2b3);
        cmd(LUT_CMD_MAKE);
        wr(LUT_IDX_WR_LO, 32'h00aa5502);
        wr(LUT_IDX_WR_HI, 32'h0168ff0e);
        cmd(LUT_CMD_MAKE);
        cmd(LUT_CMD_FIRST);
        rd(LUT_IDX_RD_HI, HI_MSK, 32'h0141a2b3);
        rd(LUT_IDX_RD_LO, 32'hffffffff, 32'hc0a81101);
        rd(LUT_IDX_WR_LO, 32'hffffffff, 32'h00aa5502);
        rd(LUT_IDX_STS, 32'hffffffff, 32'h0);
        wr(LUT_IDX_RD_LO, 32'hffffffff);
        rd(LUT_IDX_RD_LO, 32'hffffffff, 32'hc0a81101);
        rd(LUT_IDX_RD_HI, HI_MSK, 32'h0141a2b3);
        cmd(LUT_CMD_NEXT);
        rd(LUT_IDX_RD_LO, 32'hffffffff, 32'h00aa5502);
        rd(LUT_IDX_RD_HI, HI_MSK, 32'h0168ff0e);
        cmd(LUT_CMD_NEXT);
        rd(LUT_IDX_RD_HI, 32'h01800000, 32'h00800000);
        cmd(LUT_CMD_FIRST);
        rd(LUT_IDX_RD_LO, 32'hffffffff, 32'hc0a81101);
        rd(LUT_IDX_RD_HI, 32'h01800000, 32'h01000000);
        results();
    end
endmodule
